// ===== logic/ipsel_map.svh
// Register offsets, field positions, reset values and idle level of the input pin select block
`ifndef IPSEL_MAP_SVH
`define IPSEL_MAP_SVH

// ==========================================================================
// Register offsets
`define IPSEL_TMR_UART_OFS   20'h4_0098
`define IPSEL_IIO_OFS        20'h4_009A
`define IPSEL_SBUS_OFS       20'h4_009D
`define IPSEL_PU_BASE_OFS    20'h4_00A0
`define IPSEL_PORT_MODE_OFS  20'h4_00A8

// ==========================================================================
// Field positions (low bit of each field)
`define IPSEL_TA_POS         0
`define IPSEL_U3_POS         2
`define IPSEL_U4_POS         4
`define IPSEL_TB_POS         6
`define IPSEL_INTELLIGENT_IO_GROUP0_POS       0
`define IPSEL_Q0_POS         2
`define IPSEL_INTELLIGENT_IO_GROUP1_POS       4
`define IPSEL_Q1_POS         6
`define IPSEL_SB0_POS        0
`define IPSEL_SB1_POS        2
`define IPSEL_SB2_POS        4
`define IPSEL_P1_OD_POS      0

// ==========================================================================
// Reset values and masks
`define IPSEL_SEL_RST        8'h00
`define IPSEL_PU_RST         8'h00
`define IPSEL_MODE_RST       1'b0
`define IPSEL_SBUS_MASK      8'h3F

// Level fed to a peripheral input that has no pin selected
`define IPSEL_IDLE_LVL       1'b1

`endif

// ===== logic/ipsel_pkg.sv
// Types shared by the input pin select block
package ipsel_pkg;
    typedef logic [7:0] ipsel_byte_t;
    typedef logic [1:0] ipsel_code_t;
    typedef logic [2:0] ipsel_quad_t;
endpackage

// ===== logic/ipsel_pullup.sv
// Per-pin pull-up enables from per-group enable bits and pin directions
`timescale 1ns/1ps
module ipsel_pullup #(
    parameter int GROUPS = 40
) (
    input  wire logic                  clk_i,    // System clock
    input  wire logic                  rst_n_i,  // Sync reset, active low
    input  wire logic [GROUPS-1:0]     grp_en_i, // One enable per four pins
    input  wire logic [4*GROUPS-1:0]   dir_i,    // Direction bits, 1 = output
    output logic      [4*GROUPS-1:0]   pu_en_o   // Pull-up on, per pin
);
    logic [4*GROUPS-1:0] pu_reg;
    logic [4*GROUPS-1:0] pu_next;

    // ======================================================================
    // Group fan-out
    genvar g;
    generate
        for (g = 0; g < GROUPS; g++) begin : g_grp
            // Four pins share one bit; outputs never see a pull-up
            always_comb begin
                pu_next[4*g +: 4] = {4{grp_en_i[g]}} & ~dir_i[4*g +: 4]; // R14 R15
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pu_reg <= '0;
        end else begin
            pu_reg <= pu_next;
        end
    end

    assign pu_en_o = pu_reg;
endmodule // ipsel_pullup

// ===== logic/ipsel_top.sv
// Input pin select, pull-up enables and port 1 output mode
//
// Function
// R1 - Each multi-pin input gets exactly one pin
// R2 - Timer A inputs from port 3 or 7/8
// R3 - UART ch3 inputs from four pin sets
// R4 - UART ch4 code 10 routes receive only
// R5 - Timer B six inputs per select code
// R6 - IIO group 0 from port 15/1/5
// R7 - Group 0 phase and index pin sets
// R8 - IIO group 1 from four pin sets
// R9 - Group 1 phase select matches group 0
// R10 - Serial bus 0 data from three sets
// R11 - Serial bus 1 data from three sets
// R12 - Serial bus 2 data from two sets
// R13 - IIO select register resets zero, all RW
// R14 - One pull-up bit per four pins
// R15 - Pull-ups act only on input pins
// R16 - Port 1 bit set turns off high drive
// R17 - Unlisted codes feed inactive constant level
// R18 - All selects and controls reset to zero
`timescale 1ns/1ps
`include "ipsel_map.svh"
module ipsel_top import ipsel_pkg::*; #(
    parameter int PU_REGS = 5
) (
    input  wire logic                   clk_i,       // System clock, 10 MHz
    input  wire logic                   rst_n_i,     // Sync reset, active low
    input  wire logic [19:0]            addr_i,      // Register address
    input  wire logic [7:0]             wdata_i,     // Write data
    input  wire logic                   wr_i,        // Write strobe
    input  wire logic                   rd_i,        // Read strobe
    output logic      [7:0]             rdata_o,     // Read data, cycle after rd_i
    input  wire logic [7:0]             p1_i,        // Port 1 pin levels
    input  wire logic [7:0]             p3_i,        // Port 3 pin levels
    input  wire logic [7:0]             p4_i,        // Port 4 pin levels
    input  wire logic [7:0]             p5_i,        // Port 5 pin levels
    input  wire logic [7:0]             p6_i,        // Port 6 pin levels
    input  wire logic [7:0]             p7_i,        // Port 7 pin levels
    input  wire logic [7:0]             p8_i,        // Port 8 pin levels
    input  wire logic [7:0]             p9_i,        // Port 9 pin levels
    input  wire logic [4:0]             p11_i,       // Port 11 pin levels
    input  wire logic [7:0]             p12_i,       // Port 12 pin levels
    input  wire logic [7:0]             p15_i,       // Port 15 pin levels
    input  wire logic [32*PU_REGS-1:0]  dir_i,       // Direction bits, 1 = output
    output logic      [32*PU_REGS-1:0]  pu_en_o,     // Pull-up enable per pin
    output logic                        p1_hi_off_o, // Port 1 high-side drive off
    output logic      [7:0]             ta_in_o,     // Timer A pins, see order below
    output logic      [2:0]             u3_in_o,     // UART ch3 {cts, rxd, clk}
    output logic      [2:0]             u4_in_o,     // UART ch4 {cts, rxd, clk}
    output logic      [5:0]             tb_in_o,     // Timer B channel 5..0
    output logic      [7:0]             intelligent_io_group0_in_o,   // IIO group 0 inputs 7..0
    output logic      [2:0]             q0_in_o,     // Group 0 {index, phase b, phase a}
    output logic      [7:0]             intelligent_io_group1_in_o,   // IIO group 1 inputs 7..0
    output logic      [2:0]             q1_in_o,     // Group 1 {index, phase b, phase a}
    output logic      [1:0]             sb0_in_o,    // Serial bus 0 {ssi, sso}
    output logic      [1:0]             sb1_in_o,    // Serial bus 1 {ssi, sso}
    output logic      [1:0]             sb2_in_o     // Serial bus 2 {ssi, sso}
);
    localparam logic I = `IPSEL_IDLE_LVL;

    // ======================================================================
    // Register file
    ipsel_byte_t             tmr_uart_reg, tmr_uart_next;
    ipsel_byte_t             iio_reg, iio_next;
    ipsel_byte_t             sbus_reg, sbus_next;
    logic [7:0]              pu_reg [PU_REGS];
    logic [7:0]              pu_next [PU_REGS];
    logic                    mode_reg, mode_next;
    logic [7:0]              rdata_reg, rdata_next;
    logic [8*PU_REGS-1:0]    pu_flat;

    always_comb begin
        tmr_uart_next = tmr_uart_reg;
        iio_next      = iio_reg;
        sbus_next     = sbus_reg;
        mode_next     = mode_reg;
        pu_next       = pu_reg;
        rdata_next    = 8'h00;
        if (wr_i) begin
            if (addr_i == `IPSEL_TMR_UART_OFS) tmr_uart_next = wdata_i;
            if (addr_i == `IPSEL_IIO_OFS)      iio_next = wdata_i; // R13
            if (addr_i == `IPSEL_SBUS_OFS)     sbus_next = wdata_i & `IPSEL_SBUS_MASK;
            if (addr_i == `IPSEL_PORT_MODE_OFS) mode_next = wdata_i[`IPSEL_P1_OD_POS];
            for (int k = 0; k < PU_REGS; k++) begin
                if (addr_i == `IPSEL_PU_BASE_OFS + 20'(k)) pu_next[k] = wdata_i;
            end
        end
        // Unmapped reads return zero; the read never stalls
        if (rd_i) begin
            if (addr_i == `IPSEL_TMR_UART_OFS)  rdata_next = tmr_uart_reg;
            if (addr_i == `IPSEL_IIO_OFS)       rdata_next = iio_reg; // R13
            if (addr_i == `IPSEL_SBUS_OFS)      rdata_next = sbus_reg;
            if (addr_i == `IPSEL_PORT_MODE_OFS) rdata_next = {7'h00, mode_reg};
            for (int k = 0; k < PU_REGS; k++) begin
                if (addr_i == `IPSEL_PU_BASE_OFS + 20'(k)) rdata_next = pu_reg[k];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tmr_uart_reg <= `IPSEL_SEL_RST; // R18
            iio_reg      <= `IPSEL_SEL_RST; // R13 R18
            sbus_reg     <= `IPSEL_SEL_RST; // R18
            mode_reg     <= `IPSEL_MODE_RST; // R18
            rdata_reg    <= 8'h00;
            for (int k = 0; k < PU_REGS; k++) begin
                pu_reg[k] <= `IPSEL_PU_RST; // R18
            end
        end else begin
            tmr_uart_reg <= tmr_uart_next;
            iio_reg      <= iio_next;
            sbus_reg     <= sbus_next;
            mode_reg     <= mode_next;
            rdata_reg    <= rdata_next;
            pu_reg       <= pu_next;
        end
    end

    // ======================================================================
    // Select fields
    logic        ta_sel;
    ipsel_code_t u3_sel, u4_sel, tb_sel, intelligent_io_group0_sel, q0_sel, intelligent_io_group1_sel, q1_sel;
    ipsel_code_t sb0_sel, sb1_sel, sb2_sel;

    assign ta_sel   = tmr_uart_reg[`IPSEL_TA_POS];
    assign u3_sel   = tmr_uart_reg[`IPSEL_U3_POS +: 2];
    assign u4_sel   = tmr_uart_reg[`IPSEL_U4_POS +: 2];
    assign tb_sel   = tmr_uart_reg[`IPSEL_TB_POS +: 2];
    assign intelligent_io_group0_sel = iio_reg[`IPSEL_INTELLIGENT_IO_GROUP0_POS +: 2];
    assign q0_sel   = iio_reg[`IPSEL_Q0_POS +: 2];
    assign intelligent_io_group1_sel = iio_reg[`IPSEL_INTELLIGENT_IO_GROUP1_POS +: 2];
    assign q1_sel   = iio_reg[`IPSEL_Q1_POS +: 2];
    assign sb0_sel  = sbus_reg[`IPSEL_SB0_POS +: 2];
    assign sb1_sel  = sbus_reg[`IPSEL_SB1_POS +: 2];
    assign sb2_sel  = sbus_reg[`IPSEL_SB2_POS +: 2];

    // Both groups share one phase and index pin map
    function automatic ipsel_quad_t quad_pins(ipsel_code_t c, logic [7:0] p3,
                                              logic [7:0] p7, logic [7:0] p8);
        case (c)
            2'b00:   quad_pins = {p8[3], p8[1], p8[0]};
            2'b01:   quad_pins = {p8[2], p7[7], p7[6]};
            2'b10:   quad_pins = {p8[3], p3[1], p3[0]};
            default: quad_pins = {p8[2], p3[1], p3[0]};
        endcase
    endfunction

    // ======================================================================
    // Pin routing; every case drives one pin or the idle level
    logic [7:0] ta_next, intelligent_io_group0_next, intelligent_io_group1_next;
    logic [2:0] u3_next, u4_next, q0_next, q1_next;
    logic [5:0] tb_next;
    logic [1:0] sb0_next, sb1_next, sb2_next;

    always_comb begin
        // Order: TA0 out, TA1 out, TA1 in, TA2 out, TA2 in, TA3 out, TA4 out, TA4 in
        if (!ta_sel) begin
            ta_next = {p3_i[7], p3_i[6], p3_i[1], p3_i[5], p3_i[4],
                       p3_i[3], p3_i[2], p3_i[0]}; // R1 R2
        end else begin
            ta_next = {p8_i[1], p8_i[0], p7_i[6], p7_i[5], p7_i[4],
                       p7_i[3], p7_i[2], p7_i[0]}; // R2
        end
        case (u3_sel)
            2'b00:   u3_next = {p4_i[0], p4_i[2], p4_i[1]}; // R3
            2'b01:   u3_next = {p8_i[1], p8_i[0], p7_i[7]}; // R3
            2'b10:   u3_next = {p15_i[3], p15_i[2], p15_i[1]}; // R3
            default: u3_next = {p9_i[3], p9_i[1], p9_i[0]}; // R3
        endcase
        case (u4_sel)
            2'b00:   u4_next = {p9_i[4], p9_i[7], p9_i[5]};
            2'b01:   u4_next = {p3_i[7], p3_i[5], p3_i[4]};
            2'b10:   u4_next = {I, p7_i[5], I}; // R4 R17
            default: u4_next = {p15_i[7], p15_i[5], p15_i[6]};
        endcase
        case (tb_sel)
            2'b00:   tb_next = {p6_i[3], p9_i[4], p9_i[3], p6_i[2], p6_i[1], p6_i[0]}; // R5
            2'b01:   tb_next = {p7_i[1], p9_i[4], p9_i[3], p9_i[7], p3_i[7], p1_i[4]}; // R5
            2'b10:   tb_next = {p7_i[1], p9_i[4], p9_i[3], p9_i[2], p9_i[1], p9_i[0]}; // R5
            default: tb_next = {p6_i[3], p9_i[4], p11_i[4], p6_i[2], p6_i[1], p3_i[5]}; // R5
        endcase
        case (intelligent_io_group0_sel)
            2'b00:   intelligent_io_group0_next = p15_i; // R6
            2'b01:   intelligent_io_group0_next = p1_i; // R6
            2'b10:   intelligent_io_group0_next = p5_i; // R6
            default: intelligent_io_group0_next = {8{I}}; // R6 R17
        endcase
        q0_next = quad_pins(q0_sel, p3_i, p7_i, p8_i); // R7
        case (intelligent_io_group1_sel)
            2'b00:   intelligent_io_group1_next = {p7_i[1], p7_i[0], p8_i[1], p7_i[7],
                                  p7_i[6], p7_i[5], p7_i[4], p7_i[3]}; // R8
            2'b01:   intelligent_io_group1_next = {{4{I}}, p11_i[3:0]}; // R8 R17
            2'b10:   intelligent_io_group1_next = p1_i; // R8
            default: intelligent_io_group1_next = p4_i; // R8
        endcase
        q1_next = quad_pins(q1_sel, p3_i, p7_i, p8_i); // R9
        case (sb0_sel)
            2'b00:   sb0_next = {p1_i[2], p1_i[0]}; // R10
            2'b01:   sb0_next = {p6_i[2], p6_i[3]}; // R10
            2'b10:   sb0_next = {p12_i[6], p12_i[4]}; // R10
            default: sb0_next = {I, I}; // R17
        endcase
        case (sb1_sel)
            2'b00:   sb1_next = {p4_i[6], p4_i[4]}; // R11
            2'b01:   sb1_next = {p6_i[6], p6_i[7]}; // R11
            2'b10:   sb1_next = {p12_i[2], p12_i[0]}; // R11
            default: sb1_next = {I, I}; // R17
        endcase
        case (sb2_sel)
            2'b00:   sb2_next = {p5_i[6], p5_i[4]}; // R12
            2'b01:   sb2_next = {p7_i[1], p7_i[0]}; // R12
            default: sb2_next = {I, I}; // R17
        endcase
    end

    // ======================================================================
    // Output registers; one cycle from pin to peripheral
    logic [47:0] route_reg;
    logic [47:0] route_next;

    assign route_next = {ta_next, u3_next, u4_next, tb_next, intelligent_io_group0_next, q0_next,
                         intelligent_io_group1_next, q1_next, sb0_next, sb1_next, sb2_next};

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            route_reg <= {48{I}};
        end else begin
            route_reg <= route_next; // R1
        end
    end

    assign {ta_in_o, u3_in_o, u4_in_o, tb_in_o, intelligent_io_group0_in_o, q0_in_o,
            intelligent_io_group1_in_o, q1_in_o, sb0_in_o, sb1_in_o, sb2_in_o} = route_reg;
    assign rdata_o     = rdata_reg;
    assign p1_hi_off_o = mode_reg; // R16

    // ======================================================================
    // Pull-up fan-out
    genvar r;
    generate
        for (r = 0; r < PU_REGS; r++) begin : g_pu
            assign pu_flat[8*r +: 8] = pu_reg[r];
        end
    endgenerate

    ipsel_pullup #(
        .GROUPS (8*PU_REGS)
    ) u_pullup (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .grp_en_i (pu_flat), // R14
        .dir_i    (dir_i),
        .pu_en_o  (pu_en_o)
    );
endmodule // ipsel_top

// ===== tb/ipsel_top_bench.sv
// Self-checking bench for the input pin select block
`timescale 1ns/1ps
`include "ipsel_map.svh"
module ipsel_top_bench;
    logic         clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [19:0]  addr_i = '0;
    logic [7:0]   wdata_i = '0, p1_i, p3_i, p4_i, p5_i, p6_i, p7_i, p8_i, p9_i, p12_i, p15_i;
    logic [4:0]   p11_i;
    logic [159:0] dir_i = '0, pu_en_o;
    logic [7:0]   rdata_o, ta_in_o, intelligent_io_group0_in_o, intelligent_io_group1_in_o;
    logic [5:0]   tb_in_o;
    logic [2:0]   u3_in_o, u4_in_o, q0_in_o, q1_in_o;
    logic [1:0]   sb0_in_o, sb1_in_o, sb2_in_o;
    logic         p1_hi_off_o;
    int           err_count = 0, num_checks = 0;

    ipsel_top #(.PU_REGS(5)) dut_u (.*);

    always #50 clk_i = ~clk_i;

    // ==========================================================================
    // Helpers
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // Write, then wait until routed outputs follow the new select
    task automatic sel(input logic [19:0] a, input logic [7:0] d);
        wr(a, d);
        @(posedge clk_i);
        #1;
    endtask
    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, e);
    endtask
    // Each port gets its own pattern so a wrong pin shows up
    task automatic pins(input logic [7:0] s);
        @(posedge clk_i);
        p1_i <= s ^ 8'h5A;
        p3_i <= s ^ 8'h3C;
        p4_i <= s ^ 8'h96;
        p5_i <= s ^ 8'hA5;
        p6_i <= s ^ 8'h69;
        p7_i <= s ^ 8'hC3;
        p8_i <= s ^ 8'h1E;
        p9_i <= s ^ 8'hE1;
        p11_i <= s[4:0] ^ 5'h0B;
        p12_i <= s ^ 8'h78;
        p15_i <= s ^ 8'hB4;
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        conclude();
    end

    // ==========================================================================
    // Scenarios
    task automatic reset_values;
        rd(`IPSEL_TMR_UART_OFS, 8'h00);
        rd(`IPSEL_IIO_OFS, 8'h00);
        rd(`IPSEL_SBUS_OFS, 8'h00);
        rd(`IPSEL_PU_BASE_OFS + 20'h4, 8'h00);
        rd(`IPSEL_PORT_MODE_OFS, 8'h00);
    endtask
    task automatic reg_access;
        wr(`IPSEL_IIO_OFS, 8'hA5);
        rd(`IPSEL_IIO_OFS, 8'hA5);
        wr(`IPSEL_SBUS_OFS, 8'hFF);
        rd(`IPSEL_SBUS_OFS, 8'h3F);
        wr(20'h4_0099, 8'h77);
        rd(20'h4_0099, 8'h00);
    endtask
    task automatic routing;
        for (int k = 0; k < 2; k++) begin
            pins(k ? 8'hFF : 8'h00);
            sel(`IPSEL_TMR_UART_OFS, 8'h00);
            chk(ta_in_o, {p3_i[7], p3_i[6], p3_i[1], p3_i[5:2], p3_i[0]});
            chk({u3_in_o, u4_in_o, tb_in_o}, {p4_i[0], p4_i[2], p4_i[1], p9_i[4], p9_i[7],
                p9_i[5], p6_i[3], p9_i[4:3], p6_i[2:0]});
            sel(`IPSEL_TMR_UART_OFS, 8'hED);
            chk(ta_in_o, {p8_i[1:0], p7_i[6:2], p7_i[0]});
            chk({u3_in_o, u4_in_o, tb_in_o}, {p9_i[3], p9_i[1:0], 1'b1, p7_i[5], 1'b1,
                p6_i[3], p9_i[4], p11_i[4], p6_i[2:1], p3_i[5]});
            sel(`IPSEL_TMR_UART_OFS, 8'h54);
            chk({u3_in_o, u4_in_o, tb_in_o}, {p8_i[1:0], p7_i[7], p3_i[7], p3_i[5:4],
                p7_i[1], p9_i[4:3], p9_i[7], p3_i[7], p1_i[4]});
            sel(`IPSEL_TMR_UART_OFS, 8'hB8);
            chk({u3_in_o, u4_in_o, tb_in_o}, {p15_i[3:1], p15_i[7], p15_i[5], p15_i[6],
                p7_i[1], p9_i[4:0]});
            sel(`IPSEL_IIO_OFS, 8'h00);
            chk({intelligent_io_group0_in_o, q0_in_o, intelligent_io_group1_in_o, q1_in_o}, {p15_i, p8_i[3], p8_i[1:0],
                p7_i[1:0], p8_i[1], p7_i[7:3], p8_i[3], p8_i[1:0]});
            sel(`IPSEL_IIO_OFS, 8'h55);
            chk({intelligent_io_group0_in_o, q0_in_o, intelligent_io_group1_in_o, q1_in_o}, {p1_i, p8_i[2], p7_i[7:6],
                4'hF, p11_i[3:0], p8_i[2], p7_i[7:6]});
            sel(`IPSEL_IIO_OFS, 8'hAA);
            chk({intelligent_io_group0_in_o, q0_in_o, intelligent_io_group1_in_o, q1_in_o}, {p5_i, p8_i[3], p3_i[1:0],
                p1_i, p8_i[3], p3_i[1:0]});
            sel(`IPSEL_IIO_OFS, 8'hFF);
            chk({intelligent_io_group0_in_o, q0_in_o, intelligent_io_group1_in_o, q1_in_o}, {8'hFF, p8_i[2], p3_i[1:0],
                p4_i, p8_i[2], p3_i[1:0]});
            sel(`IPSEL_SBUS_OFS, 8'h00);
            chk({sb0_in_o, sb1_in_o, sb2_in_o}, {p1_i[2], p1_i[0], p4_i[6], p4_i[4],
                p5_i[6], p5_i[4]});
            sel(`IPSEL_SBUS_OFS, 8'h15);
            chk({sb0_in_o, sb1_in_o, sb2_in_o}, {p6_i[2], p6_i[3], p6_i[6], p6_i[7],
                p7_i[1], p7_i[0]});
            sel(`IPSEL_SBUS_OFS, 8'h2A);
            chk({sb0_in_o, sb1_in_o, sb2_in_o}, {p12_i[6], p12_i[4], p12_i[2], p12_i[0],
                2'b11});
            sel(`IPSEL_SBUS_OFS, 8'h3F);
            chk({sb0_in_o, sb1_in_o, sb2_in_o}, 6'h3F);
        end
    endtask
    task automatic pullups;
        // Group 0 and group 39 enabled, pin 1 an output
        @(posedge clk_i);
        dir_i <= 160'h2;
        sel(`IPSEL_PU_BASE_OFS, 8'h01);
        sel(`IPSEL_PU_BASE_OFS + 20'h4, 8'h80);
        chk({pu_en_o[159:156], |pu_en_o[155:4], pu_en_o[3:0]}, 9'h1ED);
        @(posedge clk_i);
        dir_i <= '1;
        repeat (2) @(posedge clk_i);
        #1;
        chk(|pu_en_o, 1'b0);
    endtask
    task automatic port_mode;
        sel(`IPSEL_PORT_MODE_OFS, 8'h01);
        chk(p1_hi_off_o, 1'b1);
        rd(`IPSEL_PORT_MODE_OFS, 8'h01);
        sel(`IPSEL_PORT_MODE_OFS, 8'h00);
        chk(p1_hi_off_o, 1'b0);
    endtask

    // ==========================================================================
    // Main sequence
    initial begin
        pins(8'h00);
        repeat (11) @(posedge clk_i);
        rst_n_i <= 1'b1;
        reset_values();
        reg_access();
        routing();
        pullups();
        port_mode();
        conclude();
    end
endmodule // ipsel_top_bench

// ===== tb/ipsel_top_sva.sv
// Concurrent checks on the ports of the input pin select block
`timescale 1ns/1ps
`include "ipsel_map.svh"
module ipsel_top_sva #(
    parameter int PU_REGS = 5
) (
    input wire logic                   clk_i,       // Clock
    input wire logic                   rst_n_i,     // Reset
    input wire logic [19:0]            addr_i,      // Address
    input wire logic                   wr_i,        // Write
    input wire logic                   rd_i,        // Read
    input wire logic [7:0]             rdata_o,     // Read data
    input wire logic [7:0]             p3_i,        // Port 3
    input wire logic [7:0]             p7_i,        // Port 7
    input wire logic [7:0]             p9_i,        // Port 9
    input wire logic [4:0]             p11_i,       // Port 11
    input wire logic [32*PU_REGS-1:0]  dir_i,       // Directions
    input wire logic [32*PU_REGS-1:0]  pu_en_o,     // Pull-ups
    input wire logic                   p1_hi_off_o, // Port 1 mode
    input wire logic [7:0]             ta_in_o,     // Timer A
    input wire logic [5:0]             tb_in_o      // Timer B
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // ==========================================================================
    // Register port
    property p_rd_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_mode_rd;
        $past(rd_i) && $past(addr_i) == `IPSEL_PORT_MODE_OFS
            |-> rdata_o == {7'h00, $past(p1_hi_off_o)};
    endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("mode read data wrong");

    // ==========================================================================
    // Routing, one flop behind the pins; the first edge after reset is skipped
    property p_ta0;
        $past(rst_n_i) |-> ta_in_o[0] == $past(p3_i[0]) || ta_in_o[0] == $past(p7_i[0]);
    endproperty
    a_ta0: assert property (p_ta0) else $error("timer A ch0 from no listed pin");
    property p_ta_set;
        $past(rst_n_i) && $past(p3_i[0]) != $past(p7_i[0]) && ta_in_o[0] == $past(p3_i[0])
            |-> ta_in_o[7] == $past(p3_i[7]);
    endproperty
    a_ta_set: assert property (p_ta_set) else $error("timer A pins from mixed sets");
    property p_tb4; $past(rst_n_i) |-> tb_in_o[4] == $past(p9_i[4]); endproperty
    a_tb4: assert property (p_tb4) else $error("timer B ch4 not from port 9");
    property p_tb3;
        $past(rst_n_i) |-> tb_in_o[3] == $past(p9_i[3]) || tb_in_o[3] == $past(p11_i[4]);
    endproperty
    a_tb3: assert property (p_tb3) else $error("timer B ch3 from no listed pin");

    // ==========================================================================
    // Pads
    property p_pu_dir; (pu_en_o & $past(dir_i)) == '0; endproperty
    a_pu_dir: assert property (p_pu_dir) else $error("pull-up on an output pin");
    property p_pu_cause;
        $changed(pu_en_o) |-> $past(wr_i, 2) || $past(dir_i) != $past(dir_i, 2);
    endproperty
    a_pu_cause: assert property (p_pu_cause) else $error("pull-up moved unprompted");
    property p_od_cause;
        $changed(p1_hi_off_o) |-> $past(wr_i) && $past(addr_i) == `IPSEL_PORT_MODE_OFS;
    endproperty
    a_od_cause: assert property (p_od_cause) else $error("port 1 mode moved unprompted");

    c_read: cover property ($past(rd_i) && rdata_o != 8'h00);
    c_od: cover property ($rose(p1_hi_off_o));
    c_pu: cover property (pu_en_o != '0);
endmodule // ipsel_top_sva

bind ipsel_top ipsel_top_sva #(.PU_REGS(PU_REGS)) sva_u (.*);
